// ---- include/alu_pkg.sv ----
package alu_pkg;
	localparam int DATA_W = 4;
	localparam int ADDR_W = 8;
	localparam int STACK_DEPTH = 15;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ACCUM = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;

	// command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_ARG_LSB = 8;

	// flag register bit positions (also the packing of a stack entry)
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_ZERO = 1;
	localparam int FLAG_BRANCH = 2;
	localparam int FLAG_USER = 3;

	// status register fields
	localparam int STAT_RES_LSB = 0;
	localparam int STAT_CARRY = 4;
	localparam int STAT_ZERO = 5;
	localparam int STAT_TAKEN = 6;
	localparam int STAT_OVER = 7;
	localparam int STAT_UNDER = 8;
	localparam int STAT_DEPTH_LSB = 12;

	localparam logic BRANCH_RESET = 1'b1;
	localparam logic [DATA_W-1:0] ACC_RESET = 4'h0;

	typedef enum logic [4:0] {
		OP_NOP = 5'b00000,
		OP_LOAD = 5'b00001,
		OP_ADD = 5'b00010,
		OP_ADD_CARRY = 5'b00011,
		OP_SUB_REV_CARRY = 5'b00100,
		OP_CMP_REV = 5'b00101,
		OP_AND = 5'b00110,
		OP_OR = 5'b00111,
		OP_XOR = 5'b01000,
		OP_ROT_LEFT = 5'b01001,
		OP_ROT_RIGHT = 5'b01010,
		OP_PRESET_CARRY = 5'b01011,
		OP_TEST_CARRY = 5'b01100,
		OP_SET_USER = 5'b01101,
		OP_CLR_USER = 5'b01110,
		OP_TEST_USER = 5'b01111,
		OP_BRANCH = 5'b10000,
		OP_INT_ACCEPT = 5'b10001,
		OP_RETURN_INT = 5'b10010,
		OP_INPUT = 5'b10011
	} opcode_t;

	typedef enum logic [2:0] {
		SEL_PASS = 3'b000,
		SEL_ADD = 3'b001,
		SEL_SUBR = 3'b010,
		SEL_AND = 3'b011,
		SEL_OR = 3'b100,
		SEL_XOR = 3'b101,
		SEL_ROL = 3'b110,
		SEL_ROR = 3'b111
	} alu_sel_t;
endpackage

// ---- include/alu_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface alu_if;
	import alu_pkg::*;
	logic [DATA_W-1:0] acc;
	logic [DATA_W-1:0] operand;
	logic carry_in;
	alu_sel_t sel;
	logic [DATA_W-1:0] result;
	logic carry;
	logic zero;
	modport ctrl (output acc, output operand, output carry_in, output sel,
		input result, input carry, input zero);
	modport unit (input acc, input operand, input carry_in, input sel,
		output result, output carry, output zero);
endinterface
`default_nettype wire

// ---- rtl/nibble_alu.sv ----
`timescale 1ns/10ps
`default_nettype none
module nibble_alu (
	alu_if.unit bus
);
	import alu_pkg::*;

	logic [DATA_W:0] wide;

	always_comb begin
		wide = '0;
		case (bus.sel)
			SEL_ADD: begin
				wide = {1'b0, bus.acc} + {1'b0, bus.operand}
					+ {{DATA_W{1'b0}}, bus.carry_in};
			end
			SEL_SUBR: begin
				// operand minus acc as two's complement addition
				wide = {1'b0, bus.operand} + {1'b0, ~bus.acc}
					+ {{DATA_W{1'b0}}, bus.carry_in};
			end
			SEL_AND: wide = {1'b0, bus.acc & bus.operand};
			SEL_OR: wide = {1'b0, bus.acc | bus.operand};
			SEL_XOR: wide = {1'b0, bus.acc ^ bus.operand};
			SEL_ROL: begin
				wide = {bus.acc, bus.carry_in};
			end
			SEL_ROR: begin
				wide = {bus.acc[0], bus.carry_in, bus.acc[DATA_W-1:1]};
			end
			default: wide = {1'b0, bus.operand};
		endcase
	end

	assign bus.result = wide[DATA_W-1:0];
	assign bus.carry = wide[DATA_W];
	assign bus.zero = (wide[DATA_W-1:0] == '0);
endmodule
`default_nettype wire

// ---- rtl/nibble_alu_and_flags.sv ----
// Overview of operation
// - the unit works on four-bit operands, giving result, carry and zero.
// - on addition, carry is the carry out of the top sum bit.
// - subtraction adds the two's complement; carry one means no borrow.
// - on rotate, carry is the bit leaving the accumulator.
// - zero indication is one exactly when the result or moved value is 0000.
// - a four-bit accumulator holds operands and results.
// - four one-bit flags: carry, zero, branch condition and user.
// - interrupt entry pushes the flags; return from interrupt restores them.
// - add and reverse subtract with carry use and reload the carry flag.
// - compare reverse loads the carry flag with the non-borrow indication.
// - rotates through carry shift old carry in and shifted bit out.
// - test and preset copies carry to branch flag, then sets carry.
// - carry test loads branch flag with inverted carry, then clears carry.
// - zero flag follows operations, rotates, inputs and loads to accumulator.
// - a branch is taken only when the branch condition flag is one.
// - reset sets the branch flag and leaves the other flags alone.
// - the user flag is set, cleared or tested by software only.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module nibble_alu_and_flags #(
	parameter int DEPTH = alu_pkg::STACK_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [alu_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [alu_pkg::DATA_W-1:0] accumulator,
	output logic carry_flag,
	output logic zero_flag,
	output logic branch_condition_flag,
	output logic user_flag,
	output logic branch_taken
);
	import alu_pkg::*;

	localparam int DEPTH_W = $clog2(DEPTH + 1);

	if (DEPTH < 1 || DEPTH > 15) begin : depth_check
		$error("flag stack depth must be 1 to 15");
	end

	alu_if alu_bus ();

	nibble_alu alu_inst (
		.bus(alu_bus)
	);

	logic access;
	logic mapped;
	logic wr_command;
	logic wr_accum;
	logic wr_flags;
	opcode_t op;
	logic [DATA_W-1:0] arg;
	logic [15:0] last_command;
	logic [DATA_W-1:0] last_result;
	logic last_carry;
	logic last_zero;
	logic stack_over;
	logic stack_under;
	logic [DEPTH_W-1:0] depth;
	logic [3:0] flag_stack [DEPTH];
	logic [3:0] top_flags;
	logic push_ok;
	logic pop_ok;
	logic [31:0] read_word;

	logic [DATA_W-1:0] next_acc;
	logic next_acc_en;
	logic next_carry;
	logic next_zero;
	logic next_branch;
	logic next_user;

	assign access = psel & penable;
	assign mapped = (paddr == OFS_COMMAND) | (paddr == OFS_ACCUM)
		| (paddr == OFS_FLAGS) | (paddr == OFS_STATUS);
	assign wr_command = access & pwrite & (paddr == OFS_COMMAND);
	assign wr_accum = access & pwrite & (paddr == OFS_ACCUM);
	assign wr_flags = access & pwrite & (paddr == OFS_FLAGS);
	assign pready = 1'b1;
	// the status word is read only, so a write to it is an error as well
	assign pslverr = access & (~mapped | (pwrite & (paddr == OFS_STATUS)));

	assign op = opcode_t'(pwdata[CMD_OP_LSB +: 5]);
	assign arg = pwdata[CMD_ARG_LSB +: DATA_W];

	assign push_ok = (depth != DEPTH_W'(DEPTH));
	assign pop_ok = (depth != '0);
	assign top_flags = pop_ok ? flag_stack[depth - DEPTH_W'(1)] : 4'h0;

	// operand routing into the shared arithmetic unit
	always_comb begin
		alu_bus.acc = accumulator;
		alu_bus.operand = arg;
		alu_bus.carry_in = 1'b0;
		alu_bus.sel = SEL_PASS;
		case (op)
			OP_ADD: alu_bus.sel = SEL_ADD;
			OP_ADD_CARRY: begin
				alu_bus.sel = SEL_ADD;
				alu_bus.carry_in = carry_flag;
			end
			OP_SUB_REV_CARRY: begin
				alu_bus.sel = SEL_SUBR;
				alu_bus.carry_in = carry_flag;
			end
			OP_CMP_REV: begin
				alu_bus.sel = SEL_SUBR;
				alu_bus.carry_in = 1'b1;
			end
			OP_AND: alu_bus.sel = SEL_AND;
			OP_OR: alu_bus.sel = SEL_OR;
			OP_XOR: alu_bus.sel = SEL_XOR;
			OP_ROT_LEFT: begin
				alu_bus.sel = SEL_ROL;
				alu_bus.carry_in = carry_flag;
			end
			OP_ROT_RIGHT: begin
				alu_bus.sel = SEL_ROR;
				alu_bus.carry_in = carry_flag;
			end
			default: alu_bus.sel = SEL_PASS;
		endcase
	end

	// per-instruction flag and accumulator effects
	always_comb begin
		next_acc = accumulator;
		next_acc_en = 1'b0;
		next_carry = carry_flag;
		next_zero = zero_flag;
		next_branch = branch_condition_flag;
		next_user = user_flag;
		case (op)
			OP_LOAD, OP_INPUT, OP_ADD, OP_AND, OP_OR, OP_XOR: begin
				next_acc = alu_bus.result;
				next_acc_en = 1'b1;
				next_zero = alu_bus.zero;
			end
			OP_ADD_CARRY, OP_SUB_REV_CARRY, OP_ROT_LEFT, OP_ROT_RIGHT: begin
				next_acc = alu_bus.result;
				next_acc_en = 1'b1;
				next_carry = alu_bus.carry;
				next_zero = alu_bus.zero;
			end
			OP_CMP_REV: begin
				// compare leaves the accumulator intact
				next_carry = alu_bus.carry;
				next_zero = alu_bus.zero;
			end
			OP_PRESET_CARRY: begin
				next_branch = carry_flag;
				next_carry = 1'b1;
			end
			OP_TEST_CARRY: begin
				next_branch = ~carry_flag;
				next_carry = 1'b0;
			end
			OP_SET_USER: next_user = 1'b1;
			OP_CLR_USER: next_user = 1'b0;
			OP_TEST_USER: next_branch = user_flag;
			OP_RETURN_INT: begin
				if (pop_ok) begin
					next_carry = top_flags[FLAG_CARRY];
					next_zero = top_flags[FLAG_ZERO];
					next_branch = top_flags[FLAG_BRANCH];
					next_user = top_flags[FLAG_USER];
				end
			end
			default: next_acc_en = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accumulator <= ACC_RESET;
		end else if (wr_accum) begin
			accumulator <= pwdata[DATA_W-1:0];
		end else if (wr_command && next_acc_en) begin
			accumulator <= next_acc;
		end
	end

	// reset touches only the branch condition flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			branch_condition_flag <= BRANCH_RESET;
		end else if (wr_flags) begin
			branch_condition_flag <= pwdata[FLAG_BRANCH];
		end else if (wr_command) begin
			branch_condition_flag <= next_branch;
		end
	end

	// no reset here on purpose: these flags survive a reset
	always_ff @(posedge pclk) begin
		if (wr_flags) begin
			carry_flag <= pwdata[FLAG_CARRY];
			zero_flag <= pwdata[FLAG_ZERO];
			user_flag <= pwdata[FLAG_USER];
		end else if (wr_command) begin
			carry_flag <= next_carry;
			zero_flag <= next_zero;
			user_flag <= next_user;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			branch_taken <= 1'b0;
		end else if (wr_command && op == OP_BRANCH) begin
			branch_taken <= branch_condition_flag;
		end
	end

	// flag stack: a push at depth limit or a pop when empty is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			depth <= '0;
		end else if (wr_command && op == OP_INT_ACCEPT && push_ok) begin
			depth <= depth + DEPTH_W'(1);
		end else if (wr_command && op == OP_RETURN_INT && pop_ok) begin
			depth <= depth - DEPTH_W'(1);
		end
	end

	always_ff @(posedge pclk) begin
		if (wr_command && op == OP_INT_ACCEPT && push_ok) begin
			flag_stack[depth] <= {user_flag, branch_condition_flag,
				zero_flag, carry_flag};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_over <= 1'b0;
			stack_under <= 1'b0;
		end else if (wr_command) begin
			stack_over <= (op == OP_INT_ACCEPT) & ~push_ok;
			stack_under <= (op == OP_RETURN_INT) & ~pop_ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_command <= 16'h0000;
			last_result <= 4'h0;
			last_carry <= 1'b0;
			last_zero <= 1'b0;
		end else if (wr_command) begin
			last_command <= pwdata[15:0];
			last_result <= alu_bus.result;
			last_carry <= alu_bus.carry;
			last_zero <= alu_bus.zero;
		end
	end

	always_comb begin
		read_word = 32'h0000_0000;
		if (!pwrite) begin
			case (paddr)
				OFS_COMMAND: read_word[15:0] = last_command;
				OFS_ACCUM: read_word[DATA_W-1:0] = accumulator;
				OFS_FLAGS: begin
					read_word[FLAG_CARRY] = carry_flag;
					read_word[FLAG_ZERO] = zero_flag;
					read_word[FLAG_BRANCH] = branch_condition_flag;
					read_word[FLAG_USER] = user_flag;
				end
				OFS_STATUS: begin
					read_word[STAT_RES_LSB +: DATA_W] = last_result;
					read_word[STAT_CARRY] = last_carry;
					read_word[STAT_ZERO] = last_zero;
					read_word[STAT_TAKEN] = branch_taken;
					read_word[STAT_OVER] = stack_over;
					read_word[STAT_UNDER] = stack_under;
					read_word[STAT_DEPTH_LSB +: 4] = 4'(depth);
				end
				default: read_word = 32'h0000_0000;
			endcase
		end
	end

	// read data is captured at the end of the setup cycle: it then comes
	// from a flip-flop and still stands through the zero-wait access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= read_word;
		end else begin
			prdata <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/nibble_alu_and_flags_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module nibble_alu_and_flags_chk #(
	parameter int DEPTH = alu_pkg::STACK_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [alu_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [alu_pkg::DATA_W-1:0] accumulator,
	input wire logic carry_flag,
	input wire logic zero_flag,
	input wire logic branch_condition_flag,
	input wire logic user_flag,
	input wire logic branch_taken
);
	import alu_pkg::*;
	logic cmd;
	logic [4:0] op;
	logic [3:0] arg;
	assign cmd = psel && penable && pwrite && paddr == OFS_COMMAND;
	assign op = pwdata[4:0];
	assign arg = pwdata[11:8];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_add_c;
		cmd && op == 5'h03 |=> {carry_flag, accumulator} ==
			$past(accumulator) + $past(arg) + $past(carry_flag);
	endproperty
	a_add_c: assert property (p_add_c)
		else $error("add with carry wrong");
	property p_sub_r;
		cmd && op == 5'h04 |=> {carry_flag, accumulator} ==
			$past(arg) + {1'b0, ~$past(accumulator)} + $past(carry_flag);
	endproperty
	a_sub_r: assert property (p_sub_r)
		else $error("reverse sub wrong");
	property p_cmp_r;
		cmd && op == 5'h05 |=> $stable(accumulator) &&
			carry_flag == ($past(arg) >= $past(accumulator));
	endproperty
	a_cmp_r: assert property (p_cmp_r)
		else $error("compare carry wrong");
	property p_rot_l;
		cmd && op == 5'h09 |=> carry_flag == $past(accumulator[3]) &&
			accumulator == {$past(accumulator[2:0]), $past(carry_flag)};
	endproperty
	a_rot_l: assert property (p_rot_l)
		else $error("rotate left wrong");
	property p_rot_r;
		cmd && op == 5'h0A |=> carry_flag == $past(accumulator[0]) &&
			accumulator == {$past(carry_flag), $past(accumulator[3:1])};
	endproperty
	a_rot_r: assert property (p_rot_r)
		else $error("rotate right wrong");
	property p_preset;
		cmd && op == 5'h0B |=> carry_flag &&
			branch_condition_flag == $past(carry_flag);
	endproperty
	a_preset: assert property (p_preset)
		else $error("test preset wrong");
	property p_test;
		cmd && op == 5'h0C |=> !carry_flag &&
			branch_condition_flag == !$past(carry_flag);
	endproperty
	a_test: assert property (p_test) else $error("carry test wrong");
	property p_zero;
		cmd && (op == 5'h01 || op == 5'h13) |=> accumulator == $past(arg)
			&& zero_flag == (accumulator == 4'h0);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_branch;
		cmd && op == 5'h10 |=> branch_taken == $past(branch_condition_flag);
	endproperty
	a_branch: assert property (p_branch) else $error("branch wrong");
	property p_nop;
		cmd && op == 5'h00 |=> $stable({carry_flag, zero_flag, user_flag,
			branch_condition_flag, accumulator});
	endproperty
	a_nop: assert property (p_nop) else $error("idle op changed state");
endmodule
bind nibble_alu_and_flags nibble_alu_and_flags_chk #(.DEPTH(DEPTH)) chk_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.accumulator(accumulator), .carry_flag(carry_flag),
	.zero_flag(zero_flag), .branch_condition_flag(branch_condition_flag),
	.user_flag(user_flag), .branch_taken(branch_taken));
`default_nettype wire

// ---- testbench/cpu_seq_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cpu_seq_model (
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [alu_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata
);
	import alu_pkg::*;
	logic [31:0] rdata;
	logic err;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// no wait-state count assumed: the bench timeout bounds a missing ready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- testbench/nibble_alu_and_flags_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module nibble_alu_and_flags_tb;
	import alu_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, taken;
	logic carry_flag, zero_flag, branch_condition_flag, user_flag;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] acc;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	nibble_alu_and_flags nibble_alu_and_flags_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .accumulator(acc), .carry_flag(carry_flag),
		.zero_flag(zero_flag), .user_flag(user_flag),
		.branch_condition_flag(branch_condition_flag),
		.branch_taken(taken));
	cpu_seq_model cpu_seq_model_inst (.pclk(pclk), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cpu_seq_model_inst.xfer(1'b1, a, d);
	endtask
	task automatic check(input logic [7:0] a, input logic [31:0] e, input logic r);
		cpu_seq_model_inst.xfer(1'b0, a, 32'h0);
		cmp(cpu_seq_model_inst.rdata, e);
		cmp({31'h0, cpu_seq_model_inst.err}, {31'h0, r});
	endtask
	// flags nibble is {user, branch, zero, carry}
	task automatic step(input logic [3:0] a, f, input logic [4:0] op,
		input logic [3:0] arg, ea, ef);
		wr(OFS_ACCUM, {28'h0, a});
		wr(OFS_FLAGS, {28'h0, f});
		wr(OFS_COMMAND, {20'h0, arg, 3'h0, op});
		check(OFS_ACCUM, {28'h0, ea}, 1'b0);
		check(OFS_FLAGS, {28'h0, ef}, 1'b0);
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			stop_test();
		end
	end
	initial begin
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		wr(OFS_FLAGS, 32'h9);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check(OFS_FLAGS, 32'hD, 1'b0);
		check(OFS_ACCUM, 32'h0, 1'b0);
		step(4'hC, 4'h1, 5'h03, 4'h5, 4'h2, 4'h1);
		step(4'h7, 4'h0, 5'h03, 4'h9, 4'h0, 4'h3);
		step(4'hC, 4'h1, 5'h04, 4'h5, 4'h9, 4'h0);
		step(4'hC, 4'h1, 5'h05, 4'h5, 4'hC, 4'h0);
		step(4'h5, 4'h0, 5'h05, 4'h5, 4'h5, 4'h3);
		step(4'hC, 4'h1, 5'h02, 4'h4, 4'h0, 4'h3);
		step(4'h3, 4'h2, 5'h01, 4'h6, 4'h6, 4'h0);
		step(4'h3, 4'h0, 5'h13, 4'h0, 4'h0, 4'h2);
		step(4'hC, 4'h0, 5'h06, 4'h5, 4'h4, 4'h0);
		step(4'hC, 4'h0, 5'h07, 4'h5, 4'hD, 4'h0);
		step(4'hC, 4'h0, 5'h08, 4'hC, 4'h0, 4'h2);
		step(4'h9, 4'h1, 5'h09, 4'h0, 4'h3, 4'h1);
		step(4'hE, 4'h0, 5'h0A, 4'h0, 4'h7, 4'h0);
		step(4'h5, 4'h0, 5'h0B, 4'h0, 4'h5, 4'h1);
		step(4'h5, 4'h5, 5'h0C, 4'h0, 4'h5, 4'h0);
		step(4'h5, 4'h0, 5'h0C, 4'h0, 4'h5, 4'h4);
		step(4'h5, 4'h6, 5'h0D, 4'h0, 4'h5, 4'hE);
		step(4'h5, 4'hF, 5'h0E, 4'h0, 4'h5, 4'h7);
		step(4'h5, 4'h9, 5'h0F, 4'h0, 4'h5, 4'hD);
		step(4'hA, 4'hA, 5'h00, 4'h3, 4'hA, 4'hA);
		step(4'h5, 4'h0, 5'h10, 4'h0, 4'h5, 4'h0);
		cmp({31'h0, taken}, 32'h0);
		step(4'h5, 4'h4, 5'h10, 4'h0, 4'h5, 4'h4);
		cmp({31'h0, taken}, 32'h1);
		wr(OFS_FLAGS, 32'hB);
		wr(OFS_COMMAND, 32'h11);
		wr(OFS_FLAGS, 32'h4);
		wr(OFS_COMMAND, 32'h12);
		check(OFS_FLAGS, 32'hB, 1'b0);
		check(OFS_STATUS, 32'h60, 1'b0);
		wr(OFS_COMMAND, 32'h12);
		check(OFS_STATUS, 32'h160, 1'b0);
		check(OFS_FLAGS, 32'hB, 1'b0);
		repeat (16) wr(OFS_COMMAND, 32'h11);
		check(OFS_STATUS, 32'hF0E0, 1'b0);
		check(OFS_COMMAND, 32'h11, 1'b0);
		check(8'h10, 32'h0, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
